// ==== rtl/wsc_exec.sv ====
// executor for wait, stop and set-coordinate instructions
`timescale 1ns/100ps
`default_nettype none
module wsc_exec #(
   parameter int TICK_CYCLES = wsc_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   // stored program fetch
   input wire logic prog_valid_in,
   input wire wsc_pkg::wsc_instr_t prog_instr_in,
   input wire logic [15:0] prog_addr_in,
   // binary frame bytes
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   // axis status, asynchronous pins
   input wire wsc_pkg::wsc_axis_t axis_in,
   // accumulator and global parameter 84
   input wire logic [31:0] accu_in,
   input wire logic coord_nv_in,
   // program control
   output logic running_out,
   output logic pc_hold_out,
   output logic [15:0] pc_hold_addr_out,
   output logic advance_out,
   output logic branch_taken_out,
   output logic timeout_error_flag_out,
   output logic waiting_out,
   output logic sum_error_out,
   output logic [31:0] coord_rd_out,
   // nonvolatile write port
   output wsc_pkg::wsc_nv_t nv_out,
   // coordinate read port
   input wire logic [7:0] rd_axis_in,
   input wire logic [7:0] rd_index_in
);
   // ***********************
   // sources and synchronisers
   // ***********************
   localparam int AW = $bits(wsc_pkg::wsc_axis_t);
   logic tick;
   logic frm_valid;
   wsc_pkg::wsc_instr_t frm_instr;
   logic frm_err;
   logic [AW-1:0] s1, s2, s3, axis_q;
   wsc_pkg::wsc_axis_t ax;

   wsc_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .tick_out(tick)
   );

   wsc_frame u_frame (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .byte_valid_in(byte_valid_in),
      .byte_in(byte_in),
      .instr_valid_out(frm_valid),
      .instr_out(frm_instr),
      .sum_error_out(frm_err)
   );

   // three flops; level taken when the last two agree
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         axis_q <= '0;
      end else begin
         s1 <= axis_in;
         s2 <= s1;
         s3 <= s2;
         for (int i = 0; i < AW; i++) begin
            if (s2[i] == s3[i]) begin
               axis_q[i] <= s3[i];
            end
         end
      end
   end
   assign ax = axis_q;

   // ***********************
   // instruction decode
   // ***********************
   function automatic logic coord_ok(input logic [7:0] axis, input logic [7:0] idx);
      coord_ok = (axis < wsc_pkg::NUM_AXES_B) && (idx <= wsc_pkg::MAX_COORD);
   endfunction

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_SAVE = 2'b10
   } wsc_state_t;

   wsc_state_t state;
   wsc_pkg::wsc_instr_t cur;
   logic [31:0] limit;
   logic [31:0] ticks;
   logic [15:0] wait_addr;
   logic cond_hit;
   logic [1:0] ax_sel;
   logic [31:0] coord [0:wsc_pkg::NUM_AXES-1][0:wsc_pkg::NUM_COORDS-1];
   logic [7:0] sv_axis;
   logic [7:0] sv_idx;
   logic sv_all;
   logic take;
   wsc_pkg::wsc_instr_t in_i;

   // stored program wins over a frame arriving the same cycle
   assign take = (prog_valid_in && running_out) || frm_valid;
   assign in_i = (prog_valid_in && running_out) ? prog_instr_in : frm_instr;
   assign ax_sel = cur.motor[1:0];

   always_comb begin
      case (wsc_pkg::wsc_wait_t'(cur.kind[2:0]))
         wsc_pkg::WT_POS: cond_hit = ax.target_reached[ax_sel];
         wsc_pkg::WT_HOME: cond_hit = ax.home_switch_cond[ax_sel];
         wsc_pkg::WT_END: cond_hit = ax.end_switch_cond[ax_sel];
         wsc_pkg::WT_HOMING: cond_hit = ax.homing_done_cond[ax_sel];
         default: cond_hit = 1'b0;
      endcase
   end

   // ***********************
   // wait / stop sequencing
   // ***********************
   logic hit_now;
   logic tmo_now;
   logic is_ticks;
   assign is_ticks = (cur.kind == 8'h00);
   assign tmo_now = (ticks >= limit) && (is_ticks || limit != 32'h00000000);
   assign hit_now = !is_ticks && cond_hit;

   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         state <= ST_IDLE;
         cur <= '0;
         limit <= 32'h00000000;
         ticks <= 32'h00000000;
         wait_addr <= 16'h0000;
         running_out <= 1'b1;
         advance_out <= 1'b0;
         waiting_out <= 1'b0;
         pc_hold_out <= 1'b0;
         pc_hold_addr_out <= 16'h0000;
         branch_taken_out <= 1'b0;
      end else begin
         advance_out <= 1'b0;
         branch_taken_out <= 1'b0;
         case (state)
            ST_IDLE: begin
               // wait only honoured from stored program
               if (prog_valid_in && running_out && in_i.opcode == wsc_pkg::OP_WAIT
                   && in_i.kind <= 8'h04) begin
                  state <= ST_WAIT;
                  cur <= in_i;
                  limit <= (in_i.value == wsc_pkg::VAL_ACCU) ? accu_in : in_i.value;
                  ticks <= 32'h00000000;
                  wait_addr <= prog_addr_in;
                  waiting_out <= 1'b1;
                  pc_hold_out <= 1'b1;
                  pc_hold_addr_out <= prog_addr_in;
               end else if (prog_valid_in && running_out
                   && in_i.opcode == wsc_pkg::OP_STOP) begin
                  running_out <= 1'b0;
               end else if (take && in_i.opcode == wsc_pkg::OP_BRANCH) begin
                  branch_taken_out <= (in_i.kind == wsc_pkg::BR_TYPE_TIMEOUT)
                     && timeout_error_flag_out;
                  advance_out <= 1'b1;
               end else if (take) begin
                  advance_out <= 1'b1;
               end
            end
            ST_WAIT: begin
               if (tick) begin
                  ticks <= ticks + 32'h00000001;
               end
               pc_hold_addr_out <= wait_addr;
               if (hit_now || tmo_now) begin
                  state <= ST_IDLE;
                  waiting_out <= 1'b0;
                  pc_hold_out <= 1'b0;
                  advance_out <= 1'b1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // only clear-error clears it; set wins
   logic tmo_event;
   logic clr_event;
   assign tmo_event = (state == ST_WAIT) && !is_ticks && !hit_now && tmo_now;
   assign clr_event = take && (state == ST_IDLE) && in_i.opcode == wsc_pkg::OP_CLEAR_ERR;
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         timeout_error_flag_out <= 1'b0;
      end else if (tmo_event) begin
         timeout_error_flag_out <= 1'b1;
      end else if (clr_event) begin
         timeout_error_flag_out <= 1'b0;
      end
   end

   // ***********************
   // coordinate array
   // ***********************
   logic set_coordinate_cmd;
   logic sco_copy;
   assign set_coordinate_cmd = take && (state == ST_IDLE) && in_i.opcode == wsc_pkg::OP_SET_COORD;
   assign sco_copy = set_coordinate_cmd && in_i.motor == wsc_pkg::MOTOR_ALL
      && in_i.value == wsc_pkg::VAL_ZERO;

   always_ff @(posedge sys_clk_in) begin
      if (set_coordinate_cmd && !sco_copy && coord_ok(in_i.motor, in_i.kind)) begin
         coord[in_i.motor[1:0]][in_i.kind[4:0]] <= in_i.value;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         coord_rd_out <= 32'h00000000;
      end else if (coord_ok(rd_axis_in, rd_index_in)) begin
         coord_rd_out <= coord[rd_axis_in[1:0]][rd_index_in[4:0]];
      end else begin
         coord_rd_out <= 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         sum_error_out <= 1'b0;
      end else begin
         sum_error_out <= frm_err;
      end
   end

   // nonvolatile write sequencer; restore at startup is the storage side's job
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         nv_out <= '0;
         sv_axis <= 8'h00;
         sv_idx <= 8'h00;
         sv_all <= 1'b0;
      end else begin
         nv_out.wr <= 1'b0;
         if (sv_all || sv_idx != 8'h00) begin
            nv_out.wr <= 1'b1;
            nv_out.axis <= sv_axis;
            nv_out.index <= sv_idx;
            nv_out.data <= coord[sv_axis[1:0]][sv_idx[4:0]];
            if (!sv_all) begin
               if (sv_axis == wsc_pkg::NUM_AXES_B - 8'h01) begin
                  sv_idx <= 8'h00;
                  sv_axis <= 8'h00;
               end else begin
                  sv_axis <= sv_axis + 8'h01;
               end
            end else if (sv_axis == wsc_pkg::NUM_AXES_B - 8'h01) begin
               sv_axis <= 8'h00;
               if (sv_idx == wsc_pkg::MAX_COORD) begin
                  sv_all <= 1'b0;
                  sv_idx <= 8'h00;
               end else begin
                  sv_idx <= sv_idx + 8'h01;
               end
            end else begin
               sv_axis <= sv_axis + 8'h01;
            end
         end else if (sco_copy && in_i.kind == 8'h00) begin
            sv_all <= 1'b1;
            sv_idx <= 8'h01;
            sv_axis <= 8'h00;
         end else if (sco_copy && in_i.kind <= wsc_pkg::MAX_COORD) begin
            sv_idx <= in_i.kind;
            sv_axis <= 8'h00;
         end else if (set_coordinate_cmd && !sco_copy && coord_nv_in && in_i.kind != 8'h00
             && coord_ok(in_i.motor, in_i.kind)) begin
            nv_out.wr <= 1'b1;
            nv_out.axis <= in_i.motor;
            nv_out.index <= in_i.kind;
            nv_out.data <= in_i.value;
         end
      end
   end

   // ***********************
   // checks
   // ***********************
   chk_pc_hold_wait:
   assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (state == ST_WAIT) |-> pc_hold_out && waiting_out)
      else $error("pc not held during wait");
   chk_zero_never_times:
   assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (state == ST_WAIT && !is_ticks && limit == 32'h00000000 && !cond_hit)
      |=> state == ST_WAIT)
      else $error("zero timeout ended wait");
   chk_timeout_sets_flag:
   assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      tmo_event |=> timeout_error_flag_out && advance_out)
      else $error("timeout did not set flag");
   chk_flag_sticky:
   assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (timeout_error_flag_out && !$past(clr_event)) |-> $past(timeout_error_flag_out)
      || $past(tmo_event))
      else $error("flag set without timeout");
   chk_stop_halts:
   assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (state == ST_IDLE && prog_valid_in && running_out
      && prog_instr_in.opcode == wsc_pkg::OP_STOP) |=> !running_out)
      else $error("stop did not halt");
   chk_nv_zero_entry:
   assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      nv_out.wr |-> nv_out.index != 8'h00)
      else $error("entry zero written to storage");
   chk_branch_flag:
   assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      branch_taken_out |-> $past(timeout_error_flag_out))
      else $error("branch without flag");
   chk_ticks_wait_length:
   assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      (state == ST_WAIT && is_ticks && ticks < limit) |=> state == ST_WAIT)
      else $error("tick wait ended early");
endmodule
`default_nettype wire

// ==== rtl/wsc_frame.sv ====
// byte frame assembler with checksum check
`timescale 1ns/100ps
`default_nettype none
module wsc_frame (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   // byte stream
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   // assembled instruction
   output logic instr_valid_out,
   output wsc_pkg::wsc_instr_t instr_out,
   output logic sum_error_out
);
   logic [3:0] pos;
   logic [7:0] sum;
   logic [7:0] buf_b [0:7];
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         pos <= 4'h0;
         sum <= 8'h00;
      end else if (byte_valid_in) begin
         if (pos == wsc_pkg::FRAME_LAST) begin
            pos <= 4'h0;
            sum <= 8'h00;
         end else begin
            pos <= pos + 4'h1;
            sum <= sum + byte_in;
            buf_b[pos[2:0]] <= byte_in;
         end
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         instr_valid_out <= 1'b0;
         sum_error_out <= 1'b0;
         instr_out <= '0;
      end else begin
         instr_valid_out <= 1'b0;
         sum_error_out <= 1'b0;
         if (byte_valid_in && pos == wsc_pkg::FRAME_LAST) begin
            if (byte_in == sum) begin
               instr_valid_out <= 1'b1;
               instr_out <= {buf_b[1], buf_b[2], buf_b[3],
                  buf_b[4], buf_b[5], buf_b[6], buf_b[7]};
            end else begin
               sum_error_out <= 1'b1;
            end
         end
      end
   end
   chk_sum_pulse_single:
   assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      !(instr_valid_out && sum_error_out))
      else $error("checksum good and bad together");
endmodule
`default_nettype wire

// ==== rtl/wsc_pkg.sv ====
// package with constants and carriers for the wait/stop/coordinate executor
// Contract
// - wait holds program counter until done
// - type selects ticks, pos, home, end, homing
// - ticks condition waits value ticks of 10ms
// - axis conditions: value is timeout, zero none
// - axis conditions test motor field axis
// - value -1 takes accumulator as count
// - timeout sets error flag, execution continues
// - flag held until clear, branch tests it
// - stop ends program, fields ignored
// - twenty-one coordinate entries per axis, 0 to 20
// - set coordinate stores value at type, motor
// - parameter 84 selects nonvolatile mirroring
// - entry zero never saved or restored
// - coord 0, motor 255, value 0 saves all
// - coord n, motor 255, value 0 saves n
// - frame: addr, instr, type, motor, value msb first, sum
// - branch type 8 jumps when flag set
package wsc_pkg;
   // ***********************
   // opcodes and fields
   // ***********************
   localparam logic [7:0] OP_WAIT = 8'h1b;
   localparam logic [7:0] OP_STOP = 8'h1c;
   localparam logic [7:0] OP_SET_COORD = 8'h1e;
   localparam logic [7:0] OP_BRANCH = 8'h15;
   localparam logic [7:0] OP_CLEAR_ERR = 8'h24;
   localparam logic [7:0] BR_TYPE_TIMEOUT = 8'h08;
   localparam logic [7:0] MOTOR_ALL = 8'hff;
   localparam logic [7:0] GP_COORD_NV = 8'h54;
   localparam logic [31:0] VAL_ACCU = 32'hffffffff;
   localparam logic [31:0] VAL_ZERO = 32'h00000000;
   localparam int NUM_AXES = 3;
   localparam int NUM_COORDS = 21;
   localparam logic [7:0] MAX_COORD = 8'h14;
   localparam logic [7:0] NUM_AXES_B = 8'h03;
   localparam logic [3:0] FRAME_LAST = 4'h8;
   // ***********************
   // timing
   // ***********************
   localparam int CLK_HZ = 125000000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   // ***********************
   // types
   // ***********************
   typedef enum logic [2:0] {
      WT_TICKS = 3'b000,
      WT_POS = 3'b001,
      WT_HOME = 3'b010,
      WT_END = 3'b011,
      WT_HOMING = 3'b100
   } wsc_wait_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] kind;
      logic [7:0] motor;
      logic [31:0] value;
   } wsc_instr_t;
   typedef struct packed {
      logic [NUM_AXES-1:0] target_reached;
      logic [NUM_AXES-1:0] home_switch_cond;
      logic [NUM_AXES-1:0] end_switch_cond;
      logic [NUM_AXES-1:0] homing_done_cond;
   } wsc_axis_t;
   typedef struct packed {
      logic wr;
      logic [7:0] axis;
      logic [7:0] index;
      logic [31:0] data;
   } wsc_nv_t;
endpackage

// ==== rtl/wsc_tick.sv ====
// free running prescaler producing the 10 ms tick pulse
`timescale 1ns/100ps
`default_nettype none
module wsc_tick #(
   parameter int CYCLES = wsc_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   // tick pulse
   output logic tick_out
);
   logic [31:0] cnt;
   always_ff @(posedge sys_clk_in) begin
      if (!nrst_in) begin
         cnt <= 32'h00000000;
         tick_out <= 1'b0;
      end else if (cnt == 32'(CYCLES - 1)) begin
         cnt <= 32'h00000000;
         tick_out <= 1'b1;
      end else begin
         cnt <= cnt + 32'h00000001;
         tick_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== tb/wait_stop_coordinate_exec_bench.sv ====
// self-checking bench for the wait/stop/coordinate executor
`timescale 1ns/100ps
`default_nettype none
module wait_stop_coordinate_exec_bench;
   // ***********************
   // signals
   // ***********************
   localparam int T = 10;
   logic clk = 1'b0;
   logic nrst_in = 1'b0;
   logic pv = 1'b0;
   wsc_pkg::wsc_instr_t pi = '0;
   logic [15:0] pa = 16'h0000;
   logic bv = 1'b0;
   logic [7:0] bd = 8'h00;
   wsc_pkg::wsc_axis_t ax;
   logic [31:0] accu = 32'h00000000;
   logic nv_en = 1'b0;
   logic [7:0] ra = 8'h00;
   logic [7:0] ri = 8'h00;
   logic go = 1'b0;
   logic [3:0] gbit = 4'h0;
   logic [7:0] gdly = 8'h00;
   logic run_o, hold, adv, br, flag, serr, wt;
   logic [15:0] haddr;
   logic [31:0] crd;
   wsc_pkg::wsc_nv_t nv;
   int n_mismatch = 0;
   int n_tests = 0;
   int n_br = 0;
   int n_se = 0;
   wsc_pkg::wsc_nv_t nvq[$];
   logic [31:0] mem[3][21];
   initial forever #4 clk = ~clk;
   wsc_exec #(.TICK_CYCLES(T)) i_dut (
      .sys_clk_in(clk), .nrst_in(nrst_in), .prog_valid_in(pv),
      .prog_instr_in(pi), .prog_addr_in(pa), .byte_valid_in(bv),
      .byte_in(bd), .axis_in(ax), .accu_in(accu), .coord_nv_in(nv_en),
      .running_out(run_o), .pc_hold_out(hold), .pc_hold_addr_out(haddr),
      .advance_out(adv), .branch_taken_out(br),
      .timeout_error_flag_out(flag), .waiting_out(wt), .sum_error_out(serr),
      .coord_rd_out(crd), .nv_out(nv), .rd_axis_in(ra), .rd_index_in(ri)
   );
   wsc_axis_model i_axis (
      .sys_clk_in(clk), .go_in(go), .bit_in(gbit), .dly_in(gdly), .axis_out(ax)
   );
   // ***********************
   // tasks
   // ***********************
   task automatic check(input string w, input logic [55:0] s, input logic [55:0] e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic rng(input string w, input int n, input int lo, input int hi);
      check(w, 56'(n >= lo && n <= hi), 56'h1);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic send(input logic [7:0] op, k, m, input logic [31:0] v,
                       output logic [15:0] a);
      a = 16'($urandom);
      @(posedge clk);
      pv <= 1'b1;
      pi <= {op, k, m, v};
      pa <= a;
      @(posedge clk);
      pv <= 1'b0;
   endtask
   // wait count starts at the edge that takes the instruction
   task automatic run(input logic [7:0] op, k, m, input logic [31:0] v, output int n);
      logic [15:0] a;
      send(op, k, m, v, a);
      n = 0;
      // a one-cycle advance lands right after the taking edge
      #1;
      while (adv !== 1'b1 && n < 4000) begin
         @(posedge clk);
         #1;
         n++;
         if (n == 1 && op == wsc_pkg::OP_WAIT) begin
            check("hold", {hold, wt, haddr}, {2'b11, a});
         end
      end
      check("advance", adv, 56'h1);
      if (op == wsc_pkg::OP_WAIT) check("released", {hold, wt}, 56'h0);
   endtask
   task automatic axis_go(input logic [3:0] b, input logic [7:0] d);
      @(posedge clk);
      go <= 1'b1;
      gbit <= b;
      gdly <= d;
      @(posedge clk);
      go <= 1'b0;
      // let the new pin levels pass the three-flop synchroniser first
      repeat (6) @(posedge clk);
   endtask
   task automatic frame(input logic [63:0] f, input logic [7:0] s);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk);
         bv <= 1'b1;
         bd <= f[i*8+:8];
         s += f[i*8+:8];
      end
      @(posedge clk);
      bd <= s;
      @(posedge clk);
      bv <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic rd(input int a, input int i, input logic [31:0] e);
      @(posedge clk);
      ra <= 8'(a);
      ri <= 8'(i);
      @(posedge clk);
      #1;
      check("coord_rd", crd, e);
   endtask
   // ***********************
   // result watcher
   // ***********************
   always @(posedge clk) begin
      if (br === 1'b1) n_br++;
      if (serr === 1'b1) n_se++;
      if (nv.wr === 1'b1) begin
         if (nvq.size() == 0) check("nv_extra", 56'h1, 56'h0);
         else check("nv_write", nv, nvq.pop_front());
      end
   end
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
   // ***********************
   // tests
   // ***********************
   initial begin
      int n, b0;
      logic [31:0] v;
      logic [15:0] a;
      void'($urandom(70));
      repeat (8) @(posedge clk);
      nrst_in <= 1'b1;
      @(posedge clk);
      #1;
      check("run_rst", {run_o, flag}, 56'h2);
      nv_en <= 1'b1;
      for (int x = 0; x < 3; x++) begin
         for (int i = 0; i <= 20; i++) begin
            v = $urandom;
            mem[x][i] = v;
            if (i != 0) nvq.push_back({1'b1, 8'(x), 8'(i), v});
            run(wsc_pkg::OP_SET_COORD, 8'(i), 8'(x), v, n);
         end
      end
      nv_en <= 1'b0;
      mem[1][7] = 32'h80000000;
      run(wsc_pkg::OP_SET_COORD, 8'h07, 8'h01, mem[1][7], n);
      for (int x = 0; x < 3; x++) begin
         for (int i = 0; i <= 21; i++) rd(x, i, (i == 21) ? 32'h0 : mem[x][i]);
      end
      $display("test coordinates done");
      for (int i = 1; i <= 20; i++) begin
         for (int x = 0; x < 3; x++) nvq.push_back({1'b1, 8'(x), 8'(i), mem[x][i]});
      end
      run(wsc_pkg::OP_SET_COORD, 8'h00, wsc_pkg::MOTOR_ALL, 32'h0, n);
      repeat (70) @(posedge clk);
      for (int x = 0; x < 3; x++) nvq.push_back({1'b1, 8'(x), 8'h14, mem[x][20]});
      run(wsc_pkg::OP_SET_COORD, 8'h14, wsc_pkg::MOTOR_ALL, 32'h0, n);
      repeat (10) @(posedge clk);
      check("copy_left", nvq.size(), 56'h0);
      $display("test storage copy done");
      run(wsc_pkg::OP_WAIT, 8'h00, 8'h00, 32'h2, n);
      rng("ticks", n, T + 1, 2 * T + 4);
      accu <= 32'h3;
      run(wsc_pkg::OP_WAIT, 8'h00, 8'h00, wsc_pkg::VAL_ACCU, n);
      rng("accu_ticks", n, 2 * T + 1, 3 * T + 4);
      // waits come only from the program port
      for (int k = 1; k <= 4; k++) begin
         b0 = $urandom_range(2, 0);
         axis_go(4'((4 - k) * 3 + b0), 8'h28);
         run(wsc_pkg::OP_WAIT, 8'(k), 8'(b0), (k % 2) ? 32'h0 : 32'h32, n);
         rng("axis_wait", n, 34, 56);
      end
      check("no_flag", flag, 56'h0);
      $display("test waits done");
      axis_go(4'h9, 8'hff);
      run(wsc_pkg::OP_WAIT, 8'h01, 8'h00, 32'h2, n);
      rng("timeout", n, T + 1, 2 * T + 8);
      run(wsc_pkg::OP_WAIT, 8'h00, 8'h00, 32'h1, n);
      check("flag_kept", flag, 56'h1);
      b0 = n_br;
      run(wsc_pkg::OP_BRANCH, wsc_pkg::BR_TYPE_TIMEOUT, 8'h00, 32'h0, n);
      repeat (2) @(posedge clk);
      check("branch", n_br - b0, 56'h1);
      run(wsc_pkg::OP_CLEAR_ERR, 8'h00, 8'h00, 32'h0, n);
      #1;
      check("cleared", flag, 56'h0);
      run(wsc_pkg::OP_BRANCH, wsc_pkg::BR_TYPE_TIMEOUT, 8'h00, 32'h0, n);
      repeat (2) @(posedge clk);
      check("no_branch", n_br - b0, 56'h1);
      $display("test timeout flag done");
      v = $urandom;
      frame({8'h01, wsc_pkg::OP_SET_COORD, 8'h05, 8'h02, v}, 8'h00);
      rd(2, 5, v);
      frame({8'h01, wsc_pkg::OP_SET_COORD, 8'h05, 8'h02, ~v}, 8'h01);
      rd(2, 5, v);
      check("sum_err", n_se, 56'h1);
      frame({8'h01, wsc_pkg::OP_WAIT, 8'h00, 8'h00, 32'h5}, 8'h00);
      #1;
      check("frame_wait", {hold, wt}, 56'h0);
      $display("test frames done");
      send(wsc_pkg::OP_STOP, 8'($urandom), 8'($urandom), $urandom, a);
      repeat (2) @(posedge clk);
      #1;
      check("stopped", run_o, 56'h0);
      send(wsc_pkg::OP_WAIT, 8'h00, 8'h00, 32'h5, a);
      repeat (2) @(posedge clk);
      #1;
      check("after_stop", hold, 56'h0);
      $display("test stop done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// ==== tb/wsc_axis_model.sv ====
// model of the per-axis motion controllers behind the status pins
`timescale 1ns/100ps
`default_nettype none
module wsc_axis_model (
   // clock
   input wire logic sys_clk_in,
   // event request from the bench
   input wire logic go_in,
   input wire logic [3:0] bit_in,
   input wire logic [7:0] dly_in,
   // status pins
   output wsc_pkg::wsc_axis_t axis_out
);
   // ***********************
   // status generation
   // ***********************
   logic [11:0] st = 12'h000;
   logic [7:0] cnt = 8'h00;
   logic [3:0] sel = 4'h0;
   logic arm = 1'b0;
   assign axis_out = st;
   // only the chosen bit is late
   // unrelated axes and conditions go true at once, so a wrong pick ends early
   always @(posedge sys_clk_in) begin
      if (go_in) begin
         st <= ~(12'h001 << bit_in);
         sel <= bit_in;
         cnt <= dly_in;
         arm <= 1'b1;
      end else if (arm && cnt == 8'h00) begin
         st[sel] <= 1'b1;
         arm <= 1'b0;
      end else if (arm) begin
         cnt <= cnt - 8'h01;
      end
   end
endmodule
`default_nettype wire
